// ==== rtl/lane_adder.v ====
// Purpose: One unsigned lane adder with optional saturation
// Assumes: Unsigned operands of width W
// Notes:   Overflow is the carry out of the lane
`timescale 1ns/100ps
`default_nettype none

module lane_adder #(
    parameter W = 8
) (
    // Operands and saturation enable
    input  wire [W-1:0] a,
    input  wire [W-1:0] b,
    input  wire         sat,
    // Result
    output wire [W-1:0] sum,
    output wire         ovf
);
    wire [W:0] full;

    assign full = {1'b0, a} + {1'b0, b};
    assign ovf  = full[W];                                   // see RL11
    assign sum  = (sat && full[W]) ? {W{1'b1}} : full[W-1:0]; // see RL6 RL10 RL5 RL9
endmodule

`default_nettype wire

// ==== rtl/simd_add_defines.vh ====
// Purpose: Constants for the unsigned add datapath
// Assumes: 32-bit operands, control register fields at fixed positions
// Notes:   Opcode codes are local to this block
//
// Overview of operation
// RL1: The carry-setting word add writes the low 32 bits of the 33-bit zero-extended sum.
// RL2: The carry-setting word add copies sum bit 32 into control register bit 13.
// RL3: No add raises a data-dependent exception; the exception output stays low.
// RL4: The halfword add sums upper and lower 16-bit lanes independently into matching lanes.
// RL5: The wrapping halfword add keeps each lane sum modulo 65,536.
// RL6: The saturating halfword add replaces an overflowed lane with 0xFFFF.
// RL7: Any lane overflow in a vector add sets control register bit 20.
// RL8: The byte add sums four 8-bit lanes independently, bits 31..24 down to 7..0.
// RL9: The wrapping byte add keeps each lane sum modulo 256.
// RL10: The saturating byte add replaces an overflowed lane with 0xFF.
// RL11: A byte lane overflows exactly when bit 8 of its 9-bit sum is 1.
// RL12: The carry-setting word add leaves the overflow flag unchanged.
// RL13: The overflow flag is only ever set by these operations, never cleared; here a control register write (CTRL_WRITE) with bit 20 low clears it
// unless a vector add overflows in the same cycle.
`ifndef SIMD_ADD_DEFINES_VH
`define SIMD_ADD_DEFINES_VH

`define OP_W              3
`define OP_NONE           3'h0
`define OP_WORD_SET_CARRY 3'h1
`define OP_HALF_WRAP      3'h2
`define OP_HALF_SAT       3'h3
`define OP_BYTE_WRAP      3'h4
`define OP_BYTE_SAT       3'h5

`define CTRL_W            32
`define CTRL_CARRY_BIT    13
`define CTRL_OVF_BIT      20
`define CTRL_RESET        32'h00000000

`define WORD_W            32
`define HALF_W            16
`define BYTE_W            8
`define HALF_LANES        2
`define BYTE_LANES        4

`endif

// ==== rtl/simd_add_unit.v ====
// Purpose: Unsigned word and SIMD add datapath with carry and overflow flags
// Assumes: One operation per cycle issued by the core pipeline
// Notes:   Results are registered; the control register is held locally
`timescale 1ns/100ps
`default_nettype none
`include "simd_add_defines.vh"

module simd_add_unit (
    // Clock and reset
    input  wire                CLK,
    input  wire                RST_N,
    // Issue
    input  wire                ISSUE_VALID,
    input  wire [`OP_W-1:0]    OPCODE,
    input  wire [`WORD_W-1:0]  SOURCE_ONE,
    input  wire [`WORD_W-1:0]  SOURCE_TWO,
    // Control register write from the core
    input  wire                CTRL_WRITE,
    input  wire [`CTRL_W-1:0]  CTRL_WDATA,
    // Result
    output reg                 RESULT_VALID,
    output reg  [`WORD_W-1:0]  RESULT,
    output reg                 EXCEPTION,
    output reg  [`CTRL_W-1:0]  DSP_CONTROL_REGISTER
);
    wire [`WORD_W:0]       word_sum;
    wire [`WORD_W-1:0]     half_res;
    wire [`WORD_W-1:0]     byte_res;
    wire [`HALF_LANES-1:0] half_ovf;
    wire [`BYTE_LANES-1:0] byte_ovf;
    wire                   half_sat;
    wire                   byte_sat;
    reg  [`WORD_W-1:0]     result_d;
    reg  [`CTRL_W-1:0]     ctrl_d;
    reg                    valid_d;

    assign word_sum = {1'b0, SOURCE_ONE} + {1'b0, SOURCE_TWO}; // see RL1
    assign half_sat = (OPCODE == `OP_HALF_SAT);
    assign byte_sat = (OPCODE == `OP_BYTE_SAT);

    // Halfword lanes
    genvar i;
    generate
        for (i = 0; i < `HALF_LANES; i = i + 1) begin : g_half
            lane_adder #(.W(`HALF_W)) u_half (                 // see RL4
                .a   (SOURCE_ONE[i*`HALF_W +: `HALF_W]),
                .b   (SOURCE_TWO[i*`HALF_W +: `HALF_W]),
                .sat (half_sat),
                .sum (half_res[i*`HALF_W +: `HALF_W]),
                .ovf (half_ovf[i])
            );
        end
        // Byte lanes
        for (i = 0; i < `BYTE_LANES; i = i + 1) begin : g_byte
            lane_adder #(.W(`BYTE_W)) u_byte (                 // see RL8
                .a   (SOURCE_ONE[i*`BYTE_W +: `BYTE_W]),
                .b   (SOURCE_TWO[i*`BYTE_W +: `BYTE_W]),
                .sat (byte_sat),
                .sum (byte_res[i*`BYTE_W +: `BYTE_W]),
                .ovf (byte_ovf[i])
            );
        end
    endgenerate

    // Next result and control register
    always @* begin
        ctrl_d   = DSP_CONTROL_REGISTER;
        result_d = RESULT;
        valid_d  = 1'b0;
        if (CTRL_WRITE) begin
            ctrl_d = CTRL_WDATA;
        end
        if (ISSUE_VALID) begin
            case (OPCODE)
                `OP_WORD_SET_CARRY: begin
                    valid_d  = 1'b1;
                    result_d = word_sum[`WORD_W-1:0];             // see RL1
                    ctrl_d[`CTRL_CARRY_BIT] = word_sum[`WORD_W];  // see RL2 RL12
                end
                `OP_HALF_WRAP, `OP_HALF_SAT: begin
                    valid_d  = 1'b1;
                    result_d = half_res;
                    if (|half_ovf) begin
                        ctrl_d[`CTRL_OVF_BIT] = 1'b1;             // see RL7 RL13
                    end
                end
                `OP_BYTE_WRAP, `OP_BYTE_SAT: begin
                    valid_d  = 1'b1;
                    result_d = byte_res;
                    if (|byte_ovf) begin
                        ctrl_d[`CTRL_OVF_BIT] = 1'b1;             // see RL7 RL11 RL13
                    end
                end
                default: begin
                    valid_d = 1'b0;
                end
            endcase
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            RESULT_VALID         <= 1'b0;
            RESULT               <= {`WORD_W{1'b0}};
            EXCEPTION            <= 1'b0;
            DSP_CONTROL_REGISTER <= `CTRL_RESET;
        end else begin
            RESULT_VALID         <= valid_d;
            RESULT               <= result_d;
            EXCEPTION            <= 1'b0;                         // see RL3
            DSP_CONTROL_REGISTER <= ctrl_d;
        end
    end
endmodule

`default_nettype wire

// ==== test/core_writeback.sv ====
// Purpose: Core write-back stage
// Assumes: One-cycle valid pulse
// Notes: Keeps last result
`timescale 1ns/100ps
`default_nettype none
module core_writeback (
    input wire logic        clk,
    input wire logic        valid,
    input wire logic [31:0] data,
    output logic [31:0]     gpr_q
);
    always @(posedge clk) begin
        if (valid) gpr_q <= data;
    end
endmodule
`default_nettype wire

// ==== test/simd_add_chk.sv ====
// Purpose: Port checks of the add unit
// Assumes: Answer one cycle after issue
// Notes: Lane sums formed here
`timescale 1ns/100ps
`default_nettype none
module simd_add_chk (
    input wire logic        CLK, RST_N, ISSUE_VALID, CTRL_WRITE, RESULT_VALID, EXCEPTION,
    input wire logic [2:0]  OPCODE,
    input wire logic [31:0] SOURCE_ONE, SOURCE_TWO, RESULT, DSP_CONTROL_REGISTER
);
    wire logic [32:0] ws = {1'b0, SOURCE_ONE} + {1'b0, SOURCE_TWO};
    wire logic [16:0] hu = {1'b0, SOURCE_ONE[31:16]} + {1'b0, SOURCE_TWO[31:16]};
    wire logic [8:0]  b0 = {1'b0, SOURCE_ONE[7:0]} + {1'b0, SOURCE_TWO[7:0]};
    wire logic        w1 = ISSUE_VALID && OPCODE == 3'h1;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_word_sum: assert property (w1 |=> RESULT == $past(ws[31:0])) else $error("sum");
    a_word_carry: assert property (w1 |=> DSP_CONTROL_REGISTER[13] == $past(ws[32]))
        else $error("carry");
    a_word_ovf: assert property (w1 && !CTRL_WRITE |=> $stable(DSP_CONTROL_REGISTER[20]))
        else $error("flag moved");
    a_no_exception: assert property (!EXCEPTION) else $error("exception");
    a_half_wrap: assert property (ISSUE_VALID && OPCODE == 3'h2
        |=> RESULT[31:16] == $past(hu[15:0])) else $error("half wrap");
    a_half_sat: assert property (ISSUE_VALID && OPCODE == 3'h3 && hu[16]
        |=> RESULT[31:16] == 16'hFFFF) else $error("half sat");
    a_byte_sat: assert property (ISSUE_VALID && OPCODE == 3'h5
        |=> RESULT[7:0] == ($past(b0[8]) ? 8'hFF : $past(b0[7:0]))) else $error("byte sat");
    a_byte_wrap: assert property (ISSUE_VALID && OPCODE == 3'h4
        |=> RESULT[7:0] == $past(b0[7:0])) else $error("byte wrap");
    a_ovf_set: assert property (ISSUE_VALID && OPCODE > 3'h1 && OPCODE < 3'h6
        && (OPCODE[2] ? b0[8] : hu[16]) |=> DSP_CONTROL_REGISTER[20]) else $error("no flag");
    a_ovf_sticky: assert property (DSP_CONTROL_REGISTER[20] && !CTRL_WRITE
        |=> DSP_CONTROL_REGISTER[20]) else $error("flag cleared");
    a_valid_pulse: assert property (1 |=> RESULT_VALID
        == $past(ISSUE_VALID && OPCODE > 3'h0 && OPCODE < 3'h6)) else $error("valid");
endmodule
bind simd_add_unit simd_add_chk chk (.*);
`default_nettype wire

// ==== test/simd_add_unit_test.sv ====
// Purpose: Directed checks of the add unit
// Assumes: Write-back two cycles after issue
// Notes: Expected values from lane sums
`timescale 1ns/100ps
`default_nettype none
module simd_add_unit_test;
    logic CLK, RST_N, ISSUE_VALID, CTRL_WRITE, RESULT_VALID, EXCEPTION;
    logic [2:0] OPCODE;
    logic [31:0] SOURCE_ONE, SOURCE_TWO, CTRL_WDATA, RESULT, DSP_CONTROL_REGISTER, gpr;
    int fail_count = 0;
    int checks_done = 0;
    simd_add_unit dut (.*);
    core_writeback cw (.clk(CLK), .valid(RESULT_VALID), .data(RESULT), .gpr_q(gpr));
    task chk(input [31:0] g, x);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task op(input [2:0] o, input [31:0] a, b, r, input [1:0] e);
        @(posedge CLK);
        {ISSUE_VALID, OPCODE, SOURCE_ONE, SOURCE_TWO} <= {1'b1, o, a, b};
        @(posedge CLK);
        ISSUE_VALID <= 1'b0;
        @(posedge CLK);
        #1;
        chk(gpr, r);
        chk({DSP_CONTROL_REGISTER[13], DSP_CONTROL_REGISTER[20], EXCEPTION}, {e, 1'b0});
    endtask
    task wr(input [31:0] v);
        @(posedge CLK);
        {CTRL_WRITE, CTRL_WDATA} <= {1'b1, v};
        @(posedge CLK);
        CTRL_WRITE <= 1'b0;
    endtask
    task s_word;
        op(3'h1, 32'hFFFFFFFF, 32'h2, 32'h1, 2'h2);
        op(3'h2, 32'hFFFF0001, 32'h00020001, 32'h00010002, 2'h3);
        op(3'h1, 32'h1, 32'h1, 32'h2, 2'h1);
    endtask
    task s_sat;
        op(3'h3, 32'hFFFF0001, 32'h00020001, 32'hFFFF0002, 2'h1);
        op(3'h4, 32'h01FF0203, 32'h01010101, 32'h02000304, 2'h1);
    endtask
    task s_byte;
        wr(32'h0);
        op(3'h5, 32'h01FF0203, 32'h01010101, 32'h02FF0304, 2'h1);
        wr(32'h0);
        op(3'h4, 32'h01010101, 32'h01010101, 32'h02020202, 2'h0);
    endtask
    task s_sticky;
        op(3'h5, 32'h80, 32'h80, 32'hFF, 2'h1);
        op(3'h4, 32'h1, 32'h1, 32'h2, 2'h1);
        op(3'h7, 32'h5, 32'h5, 32'h2, 2'h1);
    endtask
    task s_pair;
        fork
            wr(32'h00002000);
            op(3'h5, 32'hFF, 32'h1, 32'hFF, 2'h3);
        join
    endtask
    task tally_and_finish;
        $display("checks=%0d fails=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        {RST_N, ISSUE_VALID, OPCODE, SOURCE_ONE, SOURCE_TWO, CTRL_WRITE, CTRL_WDATA} = '0;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        s_word;
        s_sat;
        s_byte;
        s_sticky;
        s_pair;
        tally_and_finish;
    end
endmodule
`default_nettype wire
